// ==== verilog/ibsf_ctrl.sv ====
// APB configuration register, input filtering and initial start control
`timescale 1ns/1ps
module ibsf_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n,
  output logic fast_mode,
  output logic scl_filt,
  output logic sda_filt,
  output logic start_seen,
  output logic stop_seen,
  output logic init_state,
  output logic bus_busy
);
  import ibsf_pkg::*;
  typedef enum logic [2:0] {
    IBSF_IDLE = 3'b001, IBSF_SETUP = 3'b010, IBSF_HOLD = 3'b100
  } ibsf_gen_t;
  logic [7:0] ctl1_r;
  logic en_r;
  logic en_d_r;
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic scl_f;
  logic sda_f;
  logic scl_i;
  logic sda_i;
  logic scl_p_r;
  logic sda_p_r;
  logic [2:0] filt;
  logic filt_on;
  logic wr;
  logic rd;
  logic start_det;
  logic stop_det;
  logic start_req;
  ibsf_gen_t gen_r;
  logic [3:0] gcnt_r;
  // Write strobe aimed at one register offset
  function automatic logic wr_hit(input logic w, input logic [11:0] a,
    input logic [11:0] off);
    return w && (a == off);
  endfunction
  // Bus condition: data leaves its old level while the clock stays high
  function automatic logic cond_hit(input logic c, input logic c_p,
    input logic d_p, input logic d);
    return c && c_p && d_p && !d;
  endfunction
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign filt = ctl1_r[IBSF_FILT_LSB +: 3];
  assign filt_on = filt != IBSF_FILT_OFF;
  assign start_req = wr_hit(wr, paddr, IBSF_TRG_OFF) && pwdata[IBSF_STT_BIT];
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
    end
  end
  ibsf_filter #(.TAPS(IBSF_FILT_TAPS)) u_fscl (
    .pclk(pclk), .presetn(presetn), .run(filt_on), .rate(filt),
    .din(scl_s_r[1]), .dout(scl_f)
  );
  ibsf_filter #(.TAPS(IBSF_FILT_TAPS)) u_fsda (
    .pclk(pclk), .presetn(presetn), .run(filt_on), .rate(filt),
    .din(sda_s_r[1]), .dout(sda_f)
  );
  assign scl_i = filt_on ? scl_f : scl_s_r[1];
  assign sda_i = filt_on ? sda_f : sda_s_r[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_p_r <= scl_i;
      sda_p_r <= sda_i;
    end
  end
  assign start_det = cond_hit(scl_i, scl_p_r, sda_p_r, sda_i);
  assign stop_det = cond_hit(scl_i, scl_p_r, !sda_p_r, !sda_i);
  // Main control register enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= en_r;
      if (wr_hit(wr, paddr, IBSF_CTL0_OFF)) begin
        en_r <= pwdata[IBSF_EN_BIT];
      end
    end
  end
  // Configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_r <= IBSF_CTL1_RST;
    end else if (wr_hit(wr, paddr, IBSF_CTL1_OFF) && !en_r) begin
      ctl1_r <= pwdata[7:0] & IBSF_CTL1_WMASK;
      if (start_det) begin
        ctl1_r[IBSF_ISE_BIT] <= 1'b0;
      end
    end else if (start_det) begin
      ctl1_r[IBSF_ISE_BIT] <= 1'b0;
    end
  end
  // Initial communication state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_state <= 1'b0;
    end else if (!en_r) begin
      init_state <= 1'b0;
    end else if (!en_d_r) begin
      init_state <= 1'b1;
    end else if (stop_det) begin
      init_state <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_busy <= 1'b0;
    end else if (start_det) begin
      bus_busy <= 1'b1;
    end else if (stop_det || !en_r) begin
      bus_busy <= 1'b0;
    end
  end
  // Start condition generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_r <= IBSF_IDLE;
      gcnt_r <= 4'h0;
    end else begin
      case (gen_r)
        IBSF_IDLE: begin
          gcnt_r <= 4'h0;
          if (start_req && en_r && init_state &&
              ctl1_r[IBSF_ISE_BIT]) begin
            gen_r <= IBSF_SETUP;
          end
        end
        IBSF_SETUP: begin
          gcnt_r <= gcnt_r + 4'h1;
          if (!en_r) begin
            gen_r <= IBSF_IDLE;
          end else if (gcnt_r == IBSF_GEN_HALF) begin
            gen_r <= IBSF_HOLD;
          end
        end
        IBSF_HOLD: begin
          if (!en_r) begin
            gen_r <= IBSF_IDLE;
          end
        end
        default: gen_r <= IBSF_IDLE;
      endcase
    end
  end
  // Pin drivers, released while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= !(en_r && gen_r != IBSF_IDLE);
      scl_oe_n <= !(en_r && gen_r == IBSF_HOLD);
    end
  end
  // Status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_mode <= 1'b0;
      scl_filt <= 1'b1;
      sda_filt <= 1'b1;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      fast_mode <= ctl1_r[IBSF_MODE_BIT];
      scl_filt <= scl_i;
      sda_filt <= sda_i;
      start_seen <= start_det;
      stop_seen <= stop_det;
    end
  end
  // APB read path, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (rd && !penable) begin
        case (paddr)
          IBSF_CTL1_OFF: prdata <= {24'h0, ctl1_r};
          IBSF_CTL0_OFF: prdata <= {24'h0, en_r, 7'h0};
          IBSF_TRG_OFF: prdata <= 32'h0;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

// ==== verilog/ibsf_pkg.sv ====
// Package of constants for the I2C mode, filter and start configuration block
// What this block does
// - Configuration is an 8-bit register at offset 0x20, reset to zero.
// - Bit 7 selects standard mode (100 kbps) or fast mode (400 kbps).
// - Filter code 000 bypasses the filter and stops its circuitry.
// - Nonzero filter code routes clock and data through the filter.
// - With initial start enable set, start trigger issues start in initial state.
// - Initial state runs from operation enable set until first stop seen.
// - Hardware clears initial start enable when a start condition is detected.
// - With initial start enable 0, no start is issued in initial state.
// - With operation enable 0 both bus pins are released.
package ibsf_pkg;
  localparam logic [11:0] IBSF_CTL1_OFF = 12'h020;
  localparam logic [11:0] IBSF_CTL0_OFF = 12'h018;
  localparam logic [11:0] IBSF_TRG_OFF = 12'h00C;
  localparam logic [7:0] IBSF_CTL1_RST = 8'h00;
  localparam logic [7:0] IBSF_CTL1_WMASK = 8'hF2;
  localparam int IBSF_MODE_BIT = 7;
  localparam int IBSF_FILT_LSB = 4;
  localparam int IBSF_ISE_BIT = 1;
  localparam int IBSF_EN_BIT = 7;
  localparam int IBSF_STT_BIT = 1;
  localparam int IBSF_SPT_BIT = 0;
  localparam logic [2:0] IBSF_FILT_OFF = 3'h0;
  localparam int IBSF_FILT_TAPS = 3;
  localparam logic [3:0] IBSF_GEN_HALF = 4'hF;
endpackage

// ==== verilog/ibsf_filter.sv ====
// Digital filter for one bus line; output changes only when all samples agree
`timescale 1ns/1ps
module ibsf_filter #(
  parameter int TAPS = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] rate,
  input wire logic din,
  output logic dout
);
  logic [TAPS-1:0] hist_r;
  logic [2:0] div_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 3'h0;
    end else if (!run || div_r >= rate) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_r <= '1;
      dout <= 1'b1;
    end else if (run && div_r == 3'h0) begin
      hist_r <= {hist_r[TAPS-2:0], din};
      if (&hist_r) begin
        dout <= 1'b1;
      end else if (~|hist_r) begin
        dout <= 1'b0;
      end
    end
  end
endmodule

// ==== sim/ibsf_chk_assertions.sv ====
// Assertions on the ports of the configuration block
`timescale 1ns/1ps
module ibsf_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic fast_mode,
  input wire logic stop_seen,
  input wire logic init_state
);
  import ibsf_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic en_r;
  logic wr;
  logic rd;
  logic cfg;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  assign cfg = paddr == IBSF_CTL1_OFF;
  // Shadow of the operation enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
    end else if (wr && paddr == IBSF_CTL0_OFF) begin
      en_r <= pwdata[IBSF_EN_BIT];
    end
  end
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_rsvd_zero: assert property (
    rd && cfg |-> (prdata & ~{24'h0, IBSF_CTL1_WMASK}) == 32'h0)
    else $error("reserved bits not zero");
  a_mode_write: assert property (
    wr && cfg && !en_r |=> ##1 fast_mode == $past(pwdata[IBSF_MODE_BIT], 2))
    else $error("mode bit not taken");
  a_mode_hold: assert property (
    wr && cfg && en_r |=> ##1 $stable(fast_mode))
    else $error("mode changed while enabled");
  a_pins_free: assert property (!en_r [*3] |-> scl_oe_n && sda_oe_n)
    else $error("pin driven while disabled");
  a_init_rise: assert property ($rose(en_r) |=> init_state)
    else $error("initial state not entered");
  a_init_end: assert property (stop_seen |=> !init_state)
    else $error("initial state kept after stop");
  cover property (stop_seen);
  cover property ($rose(init_state));
  cover property (wr && cfg);
endmodule
bind ibsf_ctrl ibsf_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .scl_oe_n, .sda_oe_n, .fast_mode,
  .stop_seen, .init_state);

// ==== sim/ibsf_bus_peer.sv ====
// Other bus party pulling the open-drain lines
`timescale 1ns/1ps
module ibsf_bus_peer (
  input wire logic pclk,
  output logic scl_rel,
  output logic sda_rel
);
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  // Release is 1; the pull-up then sets the line high
  task automatic drive(input logic c, input logic d, input int n);
    scl_rel <= c;
    sda_rel <= d;
    repeat (n) @(posedge pclk);
  endtask
endmodule

// ==== sim/i2c_mode_filter_start_config_test.sv ====
// Self-checking bench of the mode, filter and start configuration
`timescale 1ns/1ps
module i2c_mode_filter_start_config_test;
  import ibsf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, scl_oe_n, sda_oe_n, fast_mode, scl_filt, init_state;
  logic scl_rel, sda_rel, stop_seen, seen;
  logic pslverr, scl_out, sda_out, sda_filt, start_seen, bus_busy, st;
  logic bad = 1'b0;
  logic [15:0] rows [7] = '{16'h0D00, 16'h8080, 16'h9E92, 16'hA4A0,
    16'hB2B2, 16'hC8C0, 16'hD1D0};
  int err_count = 0;
  int n_tests = 0;
  int i;
  wire scl_in = scl_oe_n & scl_rel;
  wire sda_in = sda_oe_n & sda_rel;
  always #5 pclk = ~pclk;
  ibsf_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .scl_in, .sda_in, .scl_out,
    .scl_oe_n, .sda_out, .sda_oe_n, .fast_mode, .scl_filt, .sda_filt,
    .start_seen, .stop_seen, .init_state, .bus_busy);
  ibsf_bus_peer peer (.pclk, .scl_rel, .sda_rel);
  always @(posedge pclk) if (scl_filt === 1'b0) seen <= 1'b1;
  always @(posedge pclk) if (start_seen === 1'b1) st <= 1'b1;
  always @(posedge pclk) begin
    if (presetn && (pslverr | scl_out | sda_out) !== 1'b0) bad <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic results();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    results();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(IBSF_CTL1_OFF, 1'b0, 32'h0);
    chk(q, 32'h0);
    foreach (rows[k]) begin
      apb(IBSF_CTL1_OFF, 1'b1, {24'h0, rows[k][15:8]});
      apb(IBSF_CTL1_OFF, 1'b0, 32'h0);
      chk(q, {24'h0, rows[k][7:0]});
      chkb(fast_mode, rows[k][7]);
    end
    apb(12'h040, 1'b0, 32'h0);
    chk(q, 32'h0);
    chkb(scl_oe_n & sda_oe_n, 1'b1);
    for (int k = 0; k < 2; k++) begin
      seen = 1'b0;
      peer.drive(1'b0, 1'b1, 1);
      peer.drive(1'b1, 1'b1, 40);
      chkb(seen, k[0]);
      apb(IBSF_CTL1_OFF, 1'b1, 32'h82);
    end
    apb(IBSF_CTL0_OFF, 1'b1, 32'h80);
    @(posedge pclk);
    chkb(init_state, 1'b1);
    apb(IBSF_CTL1_OFF, 1'b1, 32'h0);
    apb(IBSF_CTL1_OFF, 1'b0, 32'h0);
    chk(q, 32'h82);
    st = 1'b0;
    apb(IBSF_TRG_OFF, 1'b1, 32'h2);
    i = 0;
    while (sda_oe_n !== 1'b0 && i < 10) begin
      @(posedge pclk);
      i++;
    end
    chkb(sda_oe_n, 1'b0);
    repeat (40) @(posedge pclk);
    chkb(scl_oe_n, 1'b0);
    chkb(sda_filt, 1'b0);
    chkb(st & bus_busy, 1'b1);
    apb(IBSF_CTL1_OFF, 1'b0, 32'h0);
    chk(q, 32'h80);
    apb(IBSF_CTL0_OFF, 1'b1, 32'h0);
    repeat (5) @(posedge pclk);
    chkb(scl_oe_n & sda_oe_n, 1'b1);
    apb(IBSF_CTL0_OFF, 1'b1, 32'h80);
    apb(IBSF_TRG_OFF, 1'b1, 32'h2);
    repeat (30) @(posedge pclk);
    chkb(sda_oe_n, 1'b1);
    for (int k = 0; k < 4; k++) peer.drive(k != 1, k == 3, 40);
    chkb(init_state, 1'b0);
    chkb(bus_busy, 1'b0);
    apb(IBSF_CTL0_OFF, 1'b1, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chkb(fast_mode, 1'b0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(IBSF_CTL1_OFF, 1'b0, 32'h0);
    chk(q, 32'h0);
    chkb(bad, 1'b0);
    results();
  end
endmodule
